// >>> mps_pkg.sv
`default_nettype none
package mps_pkg;
  localparam int POS_W = 32;
  localparam int SEC_N = 16;
  localparam int SEC_AW = 4;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FUNC_LO = 8'h04;
  localparam logic [7:0] REG_FUNC_HI = 8'h08;
  localparam logic [7:0] REG_FMIN = 8'h0C;
  localparam logic [7:0] REG_POS_FMAX = 8'h10;
  localparam logic [7:0] REG_PPR = 8'h14;
  localparam logic [7:0] REG_OFFSET = 8'h18;
  localparam logic [7:0] REG_POLES = 8'h1C;
  localparam logic [7:0] REG_RATED_SPD = 8'h20;
  localparam logic [7:0] REG_RATED_FRQ = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_POS_CNT = 8'h2C;
  localparam logic [7:0] REG_TARGET = 8'h30;
  localparam logic [7:0] REG_ZBIAS = 8'h34;
  localparam logic [7:0] REG_SEC_BASE = 8'h40;
  localparam logic [1:0] SEC_REGION = 2'h1;
  // Input terminal function codes
  localparam logic [7:0] FN_SEL1 = 8'h02;
  localparam logic [7:0] FN_ZSERVO = 8'h2E;
  localparam logic [7:0] FN_SPD_POS = 8'h33;
  localparam logic [7:0] FN_POS_EN = 8'h34;
  // Limits and reset values
  localparam logic signed [15:0] SEC_LIM = 16'sh270F;
  localparam logic [31:0] ZBIAS_NONE = 32'h0000270F;
  localparam logic [13:0] OFFSET_MAX = 14'h270F;
  localparam logic [15:0] FREQ_NOLIMIT = 16'hFFFF;
  localparam logic [15:0] PPR_RST = 16'h0400;
  localparam logic [6:0] POLES_RST = 7'h04;
  localparam logic [6:0] POLES_MIN = 7'h02;
  localparam logic [15:0] FMIN_RST = 16'h0005;
  localparam logic [15:0] POS_FMAX_RST = 16'h0064;
  // rpm = 120 * f / P with f held in 0.1 Hz steps
  localparam logic [4:0] RPM_K = 5'h0C;
  typedef enum logic [1:0] {MPS_SPEED, MPS_WAIT_Z, MPS_HOLD} mps_state_t;
endpackage
`default_nettype wire

// >>> mps_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mps_mem_if;
  logic we;
  logic [mps_pkg::SEC_AW-1:0] waddr;
  logic [31:0] wdata;
  logic [mps_pkg::SEC_AW-1:0] raddr;
  logic [31:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> mps_sec_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Section table: {pulse, rotations} per word, registered read
module mps_sec_mem #(
  parameter int DEPTH = mps_pkg::SEC_N
) (
  input wire logic clk_i,
  mps_mem_if.mem m
);
  logic [31:0] mem_q [DEPTH];
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  always_comb begin
    rd_d = mem_q[m.raddr];
  end
  always_ff @(posedge clk_i) begin
    if (m.we) begin
      mem_q[m.waddr] <= m.wdata;
    end
    rd_q <= rd_d;
  end
  assign m.rdata = rd_q;
endmodule
`default_nettype wire

// >>> mps_multi_position.sv
`timescale 1ns/1ps
`default_nettype none
module mps_multi_position (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic run_i,
  input wire logic [7:0] di_i,
  input wire logic [15:0] out_freq_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_z_i,
  output logic pos_mode_o,
  output logic zero_servo_o,
  output logic [3:0] speed_sel_o,
  output logic [31:0] position_target_o,
  output logic dir_fwd_o,
  output logic at_target_o,
  output logic [15:0] freq_limit_o,
  output logic decel1_sel_o,
  output logic [31:0] z_bias_o
);
  function automatic logic di_has(input logic [63:0] f, input logic [7:0] di,
                                  input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int k = 0; k < 8; k++) begin
      r = r | (di[k] & (f[8*k +: 8] == code));
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = w[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp(input logic signed [15:0] v);
    logic [15:0] r;
    r = v;
    if (v > mps_pkg::SEC_LIM) begin
      r = mps_pkg::SEC_LIM;
    end else if (v < -mps_pkg::SEC_LIM) begin
      r = -mps_pkg::SEC_LIM;
    end
    return r;
  endfunction

  mps_mem_if mif ();
  mps_sec_mem #(.DEPTH(mps_pkg::SEC_N)) u_mem (.clk_i(clk_i), .m(mif.mem));

  // Bus and configuration state
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic mode_q, mode_d;
  logic [63:0] func_q, func_d;
  logic [15:0] fmin_q, fmin_d, pfmax_q, pfmax_d, ppr_q, ppr_d;
  logic [13:0] offset_q, offset_d;
  logic [6:0] poles_q, poles_d;
  logic [15:0] spd_q, spd_d, frq_q, frq_d;
  logic req, wr;
  logic [31:0] wv;

  // Encoder, Z capture and positioning state
  mps_pkg::mps_state_t st_q, st_d;
  logic a_q, b_q, z_q, step, up, z_rise, low;
  logic [31:0] pos_q, pos_d, zpos_q, zpos_d, org_q, org_d, zbias_q, zbias_d;
  logic z_seen_q, z_seen_d;
  logic [3:0] sel_q, sel_d, sel_p_q;
  logic [31:0] tgt_q, tgt_d, sec_off;
  logic [32:0] prod;
  logic pos_mode_q, zs_q, at_q, fwd_q, dec_q;
  logic [3:0] spd_sel_q;
  logic [15:0] flim_q;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_q;
    wr = req & wb_we_i;
    ack_d = req;
    mode_d = mode_q;
    func_d = func_q;
    fmin_d = fmin_q;
    pfmax_d = pfmax_q;
    ppr_d = ppr_q;
    offset_d = offset_q;
    poles_d = poles_q;
    spd_d = spd_q;
    frq_d = frq_q;
    wv = 32'h0000_0000;
    mif.we = 1'b0;
    mif.waddr = wb_adr_i[2 +: mps_pkg::SEC_AW];
    mif.wdata = {clamp(wb_dat_i[31:16]), clamp(wb_dat_i[15:0])};
    dat_d = dat_q;
    if (wr) begin
      case (wb_adr_i)
        mps_pkg::REG_CTRL: begin
          wv = merge({31'h0, mode_q}, wb_dat_i, wb_sel_i);
          mode_d = wv[0];
        end
        mps_pkg::REG_FUNC_LO: func_d[31:0] = merge(func_q[31:0], wb_dat_i, wb_sel_i);
        mps_pkg::REG_FUNC_HI: func_d[63:32] = merge(func_q[63:32], wb_dat_i, wb_sel_i);
        mps_pkg::REG_FMIN: begin
          wv = merge({16'h0, fmin_q}, wb_dat_i, wb_sel_i);
          fmin_d = wv[15:0];
        end
        mps_pkg::REG_POS_FMAX: begin
          wv = merge({16'h0, pfmax_q}, wb_dat_i, wb_sel_i);
          pfmax_d = wv[15:0];
        end
        mps_pkg::REG_PPR: begin
          wv = merge({16'h0, ppr_q}, wb_dat_i, wb_sel_i);
          ppr_d = wv[15:0];
        end
        mps_pkg::REG_OFFSET: begin
          wv = merge({18'h0, offset_q}, wb_dat_i, wb_sel_i);
          offset_d = (wv[13:0] > mps_pkg::OFFSET_MAX) ? mps_pkg::OFFSET_MAX : wv[13:0];
        end
        mps_pkg::REG_POLES: begin
          wv = merge({25'h0, poles_q}, wb_dat_i, wb_sel_i);
          poles_d = (wv[6:0] < mps_pkg::POLES_MIN) ? mps_pkg::POLES_MIN : wv[6:0];
        end
        mps_pkg::REG_RATED_SPD: begin
          wv = merge({16'h0, spd_q}, wb_dat_i, wb_sel_i);
          spd_d = wv[15:0];
          frq_d = 16'((23'(wv[15:0]) * 23'(poles_q)) / 23'(mps_pkg::RPM_K));
        end
        mps_pkg::REG_RATED_FRQ: begin
          wv = merge({16'h0, frq_q}, wb_dat_i, wb_sel_i);
          frq_d = wv[15:0];
          spd_d = 16'((21'(wv[15:0]) * 21'(mps_pkg::RPM_K)) / 21'(poles_q));
        end
        default: begin
          mif.we = (wb_adr_i[7:6] == mps_pkg::SEC_REGION) & (wb_sel_i == 4'hF);
        end
      endcase
    end
    if (req) begin
      case (wb_adr_i)
        mps_pkg::REG_CTRL: dat_d = {31'h0, mode_q};
        mps_pkg::REG_FUNC_LO: dat_d = func_q[31:0];
        mps_pkg::REG_FUNC_HI: dat_d = func_q[63:32];
        mps_pkg::REG_FMIN: dat_d = {16'h0, fmin_q};
        mps_pkg::REG_POS_FMAX: dat_d = {16'h0, pfmax_q};
        mps_pkg::REG_PPR: dat_d = {16'h0, ppr_q};
        mps_pkg::REG_OFFSET: dat_d = {18'h0, offset_q};
        mps_pkg::REG_POLES: dat_d = {25'h0, poles_q};
        mps_pkg::REG_RATED_SPD: dat_d = {16'h0, spd_q};
        mps_pkg::REG_RATED_FRQ: dat_d = {16'h0, frq_q};
        mps_pkg::REG_STATUS: dat_d = {24'h0, sel_q, z_seen_q, at_q, pos_mode_q, zs_q};
        mps_pkg::REG_POS_CNT: dat_d = pos_q;
        mps_pkg::REG_TARGET: dat_d = tgt_q;
        mps_pkg::REG_ZBIAS: dat_d = zbias_q;
        default: dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      mode_q <= 1'b0;
      func_q <= 64'h0;
      fmin_q <= mps_pkg::FMIN_RST;
      pfmax_q <= mps_pkg::POS_FMAX_RST;
      ppr_q <= mps_pkg::PPR_RST;
      offset_q <= 14'h0;
      poles_q <= mps_pkg::POLES_RST;
      spd_q <= 16'h0;
      frq_q <= 16'h0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      mode_q <= mode_d;
      func_q <= func_d;
      fmin_q <= fmin_d;
      pfmax_q <= pfmax_d;
      ppr_q <= ppr_d;
      offset_q <= offset_d;
      poles_q <= poles_d;
      spd_q <= spd_d;
      frq_q <= frq_d;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Terminal functions
  logic [3:0] sel_bits;
  logic zs_req, spd_pos, pos_en;
  for (genvar i = 0; i < 4; i++) begin : g_sel
    assign sel_bits[i] = di_has(func_q, di_i, 8'(mps_pkg::FN_SEL1 + 8'(i)));
  end
  assign zs_req = di_has(func_q, di_i, mps_pkg::FN_ZSERVO);
  assign spd_pos = di_has(func_q, di_i, mps_pkg::FN_SPD_POS);
  assign pos_en = di_has(func_q, di_i, mps_pkg::FN_POS_EN);

  // Quadrature decode, Z capture and positioning
  always_comb begin
    step = enc_a_i ^ a_q ^ enc_b_i ^ b_q;
    up = ~(a_q ^ enc_b_i);
    z_rise = enc_z_i & ~z_q;
    low = out_freq_i < fmin_q;
    pos_d = pos_q;
    if (step) begin
      pos_d = up ? pos_q + 32'h1 : pos_q - 32'h1;
    end
    z_seen_d = z_seen_q | z_rise;
    zpos_d = z_rise ? pos_q : zpos_q;
    zbias_d = z_seen_q ? pos_q - zpos_q : mps_pkg::ZBIAS_NONE;
    st_d = st_q;
    org_d = org_q;
    sel_d = sel_q;
    case (st_q)
      mps_pkg::MPS_SPEED: begin
        if (run_i & zs_req & low) begin
          if (mode_q) begin
            st_d = mps_pkg::MPS_WAIT_Z;
          end else begin
            st_d = mps_pkg::MPS_HOLD;
            org_d = pos_q;
          end
        end
      end
      mps_pkg::MPS_WAIT_Z: begin
        if (!(run_i & zs_req)) begin
          st_d = mps_pkg::MPS_SPEED;
        end else if (z_rise) begin
          st_d = mps_pkg::MPS_HOLD;
          org_d = pos_q + {18'h0, offset_q};
        end
      end
      mps_pkg::MPS_HOLD: begin
        if (!(run_i & zs_req)) begin
          st_d = mps_pkg::MPS_SPEED;
          sel_d = 4'h0;
        end else if (spd_pos & pos_en) begin
          sel_d = sel_bits;
        end
      end
      default: st_d = mps_pkg::MPS_SPEED;
    endcase
    mif.raddr = sel_q;
    prod = 33'($signed(mif.rdata[15:0])) * 33'($signed({1'b0, ppr_q}));
    sec_off = prod[31:0] + {{16{mif.rdata[31]}}, mif.rdata[31:16]};
    tgt_d = org_q + ((sel_p_q == 4'h0) ? 32'h0 : sec_off);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      z_q <= 1'b0;
      pos_q <= 32'h0;
      zpos_q <= 32'h0;
      z_seen_q <= 1'b0;
      zbias_q <= mps_pkg::ZBIAS_NONE;
      st_q <= mps_pkg::MPS_SPEED;
      org_q <= 32'h0;
      sel_q <= 4'h0;
      sel_p_q <= 4'h0;
      tgt_q <= 32'h0;
      pos_mode_q <= 1'b0;
      zs_q <= 1'b0;
      at_q <= 1'b0;
      fwd_q <= 1'b0;
      dec_q <= 1'b0;
      spd_sel_q <= 4'h0;
      flim_q <= mps_pkg::FREQ_NOLIMIT;
    end else begin
      a_q <= enc_a_i;
      b_q <= enc_b_i;
      z_q <= enc_z_i;
      pos_q <= pos_d;
      zpos_q <= zpos_d;
      z_seen_q <= z_seen_d;
      zbias_q <= zbias_d;
      st_q <= st_d;
      org_q <= org_d;
      sel_q <= sel_d;
      sel_p_q <= sel_q;
      tgt_q <= tgt_d;
      pos_mode_q <= st_d == mps_pkg::MPS_HOLD;
      zs_q <= zs_req;
      at_q <= tgt_q == pos_q;
      fwd_q <= $signed(tgt_q) > $signed(pos_q);
      dec_q <= st_d == mps_pkg::MPS_HOLD;
      spd_sel_q <= (st_d == mps_pkg::MPS_HOLD && spd_pos) ? 4'h0 : sel_bits;
      flim_q <= (st_d == mps_pkg::MPS_HOLD) ? pfmax_q : mps_pkg::FREQ_NOLIMIT;
    end
  end

  assign pos_mode_o = pos_mode_q;
  assign zero_servo_o = zs_q;
  assign speed_sel_o = spd_sel_q;
  assign position_target_o = tgt_q;
  assign dir_fwd_o = fwd_q;
  assign at_target_o = at_q;
  assign freq_limit_o = flim_q;
  assign decel1_sel_o = dec_q;
  assign z_bias_o = zbias_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  lock_origin_a: assert property (st_q == mps_pkg::MPS_SPEED && !mode_q && run_i &&
    zs_req && low |=> st_q == mps_pkg::MPS_HOLD && org_q == $past(pos_q))
    else $error("origin not locked");
  z_origin_a: assert property (st_q == mps_pkg::MPS_WAIT_Z && run_i && zs_req &&
    z_rise |=> org_q == $past(pos_q) + {18'h0, $past(offset_q)})
    else $error("Z origin wrong");
  z_bias_a: assert property (!z_seen_q |=> z_bias_o == mps_pkg::ZBIAS_NONE)
    else $error("bias not 9999");
  hold_sel_a: assert property (!pos_en |=> $stable(sel_q) || sel_q == 4'h0)
    else $error("selection changed");
  fwd_count_a: assert property (step && up |=> pos_q == $past(pos_q) + 32'h1)
    else $error("count wrong");
  abs_target_a: assert property (sel_p_q == 4'h0 |=> position_target_o == $past(org_q))
    else $error("origin target wrong");
  dir_a: assert property ($signed(tgt_q) < $signed(pos_q) |=> !dir_fwd_o)
    else $error("direction wrong");
  pos_limit_a: assert property (pos_mode_o |->
    freq_limit_o == $past(pfmax_q) && decel1_sel_o)
    else $error("limit wrong");
  rated_a: assert property (wr && wb_adr_i == mps_pkg::REG_RATED_FRQ &&
    wb_sel_i == 4'hF |=> spd_q == 16'((21'($past(wb_dat_i[15:0])) *
    21'(mps_pkg::RPM_K)) / 21'(poles_q)))
    else $error("rated speed wrong");
  hold_c: cover property (st_q == mps_pkg::MPS_SPEED ##1 st_q == mps_pkg::MPS_HOLD);
  zlock_c: cover property (st_q == mps_pkg::MPS_WAIT_Z ##1 st_q == mps_pkg::MPS_HOLD);
  select_c: cover property (pos_en && spd_pos && st_q == mps_pkg::MPS_HOLD
    ##1 sel_q != 4'h0);
  arrive_c: cover property (pos_mode_o && at_target_o && sel_q != 4'h0);
endmodule
`default_nettype wire

// >>> mps_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Incremental shaft encoder: quadrature A/B and index Z
module mps_enc_model (
  input wire logic clk_i,
  output logic enc_a_o,
  output logic enc_b_o,
  output logic enc_z_o
);
  initial begin
    enc_a_o = 1'b0;
    enc_b_o = 1'b0;
    enc_z_o = 1'b0;
  end
  // A leads B going forward, B leads A in reverse; always ends at 00
  task automatic turn(input int n, input logic fwd);
    logic [1:0] ph [4];
    ph = '{2'b00, 2'b10, 2'b11, 2'b01};
    for (int i = 0; i < 4 * n; i++) begin
      repeat (4) @(posedge clk_i);
      {enc_a_o, enc_b_o} <= fwd ? ph[(i + 1) % 4] : ph[(4 - ((i + 1) % 4)) % 4];
    end
  endtask
  task automatic zpulse();
    repeat (4) @(posedge clk_i);
    enc_z_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    enc_z_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> mps_multi_position_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mps_multi_position_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, wbwe, run;
  logic [7:0] adr, di;
  logic [3:0] sel;
  logic [31:0] wdat, q;
  logic [15:0] ofreq;
  wire logic [31:0] dat_o, tgt, zb;
  wire logic ack, pmode, zs, dir, at, dec1, ea, eb, ez;
  wire logic [3:0] ssel;
  wire logic [15:0] flim;
  int error_cnt = 0;
  int total_checks = 0;
  logic [3:0] sel_t [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0};
  logic [31:0] tgt_t [5] = '{32'h200, 32'hFFFFFD00, 32'h2B0F, 32'hFFFFF800, 32'h0};
  logic dir_t [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  always #4 clk_i = ~clk_i;
  mps_enc_model enc (.clk_i(clk_i), .enc_a_o(ea), .enc_b_o(eb), .enc_z_o(ez));
  mps_multi_position uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wbwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .run_i(run), .di_i(di), .out_freq_i(ofreq), .enc_a_i(ea), .enc_b_i(eb),
    .enc_z_i(ez), .pos_mode_o(pmode), .zero_servo_o(zs), .speed_sel_o(ssel),
    .position_target_o(tgt), .dir_fwd_o(dir), .at_target_o(at), .freq_limit_o(flim),
    .decel1_sel_o(dec1), .z_bias_o(zb));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: bus timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk32(q, exp, what);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    {cyc, stb, wbwe, run} = 4'h0;
    adr = 8'h00;
    di = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    ofreq = 16'h0100;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    chk32({16'h0, flim}, 32'hFFFF, "flim rst");
    chk32(zb, 32'h270F, "zbias rst");
    rd(mps_pkg::REG_FMIN, 32'h5, "fmin");
    rd(mps_pkg::REG_POS_FMAX, 32'h64, "pfmax");
    rd(mps_pkg::REG_PPR, 32'h400, "ppr");
    rd(mps_pkg::REG_POLES, 32'h4, "poles");
    bus(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, 32'h0, "unmapped");
    $display("test reset done");
    bus(1'b1, mps_pkg::REG_RATED_FRQ, 32'h258);
    rd(mps_pkg::REG_RATED_SPD, 32'h708, "spd from f");
    bus(1'b1, mps_pkg::REG_RATED_SPD, 32'hBB8);
    rd(mps_pkg::REG_RATED_FRQ, 32'h3E8, "f from spd");
    bus(1'b1, mps_pkg::REG_POLES, 32'h1);
    rd(mps_pkg::REG_POLES, 32'h2, "poles min");
    $display("test rated done");
    bus(1'b1, mps_pkg::REG_FUNC_LO, 32'h05040302);
    bus(1'b1, mps_pkg::REG_FUNC_HI, 32'h0034332E);
    for (int k = 0; k < 16; k++) bus(1'b1, mps_pkg::REG_SEC_BASE + 8'(4 * k), 32'h0);
    bus(1'b1, 8'h44, 32'h02000000);
    bus(1'b1, 8'h48, 32'hFD000000);
    bus(1'b1, 8'h4C, 32'h4E200001);
    bus(1'b1, 8'h50, 32'h0000FFFE);
    rd(8'h44, 32'h0, "sec read");
    di <= 8'h05;
    idle(8);
    chk32({28'h0, ssel}, 32'h5, "speed bits");
    chk1(pmode, 1'b0, "no hold at speed");
    run <= 1'b1;
    di <= 8'h00;
    idle(2);
    di <= 8'h10;
    idle(4);
    chk1(pmode, 1'b0, "freq high");
    ofreq <= 16'h0000;
    idle(8);
    chk1(pmode, 1'b1, "hold");
    chk1(zs, 1'b1, "zs");
    chk32({16'h0, flim}, 32'h64, "pos fmax");
    chk1(dec1, 1'b1, "decel1");
    chk32(tgt, 32'h0, "origin");
    chk1(at, 1'b1, "at origin");
    $display("test lock done");
    di <= 8'h70;
    idle(2);
    for (int k = 0; k < 5; k++) begin
      di <= {4'h7, sel_t[k]};
      idle(8);
      chk32(tgt, tgt_t[k], "target");
      chk1(dir, dir_t[k], "dir");
      chk32({28'h0, ssel}, 32'h0, "speed bits in hold");
    end
    chk1(at, 1'b1, "at origin again");
    di <= 8'h30;
    idle(2);
    di <= 8'h31;
    idle(8);
    chk32(tgt, 32'h0, "enable off keeps");
    di <= 8'h71;
    idle(8);
    chk32(tgt, 32'h200, "enable on takes");
    $display("test select done");
    enc.turn(4, 1'b1);
    idle(8);
    rd(mps_pkg::REG_POS_CNT, 32'h10, "count up");
    enc.turn(4, 1'b0);
    idle(8);
    rd(mps_pkg::REG_POS_CNT, 32'h0, "count back");
    $display("test encoder done");
    run <= 1'b0;
    di <= 8'h00;
    idle(8);
    chk1(pmode, 1'b0, "leave hold");
    chk32({16'h0, flim}, 32'hFFFF, "no limit");
    bus(1'b1, mps_pkg::REG_CTRL, 32'h1);
    bus(1'b1, mps_pkg::REG_OFFSET, 32'hFFFF);
    rd(mps_pkg::REG_OFFSET, 32'h270F, "offset clamp");
    bus(1'b1, mps_pkg::REG_OFFSET, 32'h64);
    run <= 1'b1;
    idle(2);
    di <= 8'h10;
    idle(8);
    chk1(pmode, 1'b0, "wait z");
    chk32(zb, 32'h270F, "no z yet");
    enc.zpulse();
    idle(8);
    chk1(pmode, 1'b1, "z hold");
    chk32(zb, 32'h0, "zbias");
    chk32(tgt, 32'h64, "z origin");
    chk1(dir, 1'b1, "dir to offset");
    rd(mps_pkg::REG_STATUS, 32'hB, "status");
    rd(mps_pkg::REG_TARGET, 32'h64, "target reg");
    $display("test zlock done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
